/* File: src/irq_mask_pkg.sv */
// package: register map, field positions and carrier types of the interrupt enable mask
`default_nettype none
package irq_mask_pkg;
  localparam logic [11:0] mask_reg_offset    = 12'h000;
  localparam logic [11:0] status_reg_offset  = 12'h004;
  localparam logic [11:0] pending_reg_offset = 12'h008;
  localparam logic [7:0]  mask_reset_value   = 8'h00;
  localparam logic [31:0] unmapped_read_value = 32'h0000_0000;
  localparam int ext0_bit   = 0;
  localparam int timer0_bit = 1;
  localparam int ext1_bit   = 2;
  localparam int timer1_bit = 3;
  localparam int uart_bit   = 4;
  localparam int timer2_bit = 5;
  localparam int spi_bit    = 6;
  localparam int global_bit = 7;
  localparam int num_sources = 7;
  localparam int sync_stages = 3;

  // the enable register split into its named fields, bit 7 first
  typedef struct packed {
    logic global_irq_enable;
    logic serial_periph_irq_enable;
    logic timer2_irq_enable;
    logic uart_irq_enable;
    logic timer1_irq_enable;
    logic ext_irq1_enable;
    logic timer0_irq_enable;
    logic ext_irq0_enable;
  } irq_mask_t;

  // raw request flags from the peripherals
  typedef struct packed {
    logic spi_flag;
    logic timer2_low_overflow_flag;
    logic timer2_high_overflow_flag;
    logic uart_flag;
    logic timer1_overflow_flag;
    logic timer0_overflow_flag;
  } irq_flags_t;
endpackage : irq_mask_pkg
`default_nettype wire

/* File: src/pin_sync.sv */
// module: three-stage pin synchroniser with agreement filter
`default_nettype none
module pin_sync
  import irq_mask_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output var  logic level_out
);
  logic [sync_stages-1:0] stage_reg;
  logic [sync_stages-1:0] stage_next;
  logic                   level_reg;
  logic                   level_next;

  // shift in; the first stage is read only by the second
  always_comb begin
    stage_next = {stage_reg[sync_stages-2:0], pin_in};
    level_next = level_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
  end

  // idle level high, since the pin is active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_reg <= '1;
      level_reg <= 1'b1;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule // pin_sync
`default_nettype wire

/* File: src/interrupt_enable_mask.sv */
// module: apb-reachable interrupt enable mask gating peripheral requests to the core
//
// The address map and register access over APB were chosen for this implementation.
`default_nettype none
module interrupt_enable_mask
  import irq_mask_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // peripheral flags and active-low pins
  input  wire irq_flags_t             flags,
  input  wire logic                   ext_irq0_input_n,
  input  wire logic                   ext_irq1_input_n,
  // gated requests, one per mask bit below the global enable
  output var  logic [num_sources-1:0] irq_to_core
);
  // word geometry around the eight-bit mask
  localparam int word_width = 32;
  localparam int mask_pad   = word_width - $bits(irq_mask_t);
  localparam int src_pad    = word_width - num_sources;
  localparam int mask_lane  = 0;

  // mask and bus response state
  irq_mask_t              mask_reg;
  irq_mask_t              mask_next;
  logic [31:0]            prdata_reg;
  logic [31:0]            prdata_next;
  logic                   pready_reg;
  logic                   pready_next;
  logic                   pslverr_reg;
  logic                   pslverr_next;

  // request path
  logic [num_sources-1:0] pend;
  logic [num_sources-1:0] src_enable;
  logic [num_sources-1:0] irq_reg;
  logic [num_sources-1:0] irq_next;
  logic                   timer2_any;
  logic                   ext0_level;
  logic                   ext1_level;

  // bus decode
  logic                   access;
  logic                   mapped;
  logic                   sel_mask;
  logic                   sel_status;
  logic                   sel_pending;
  logic                   wr_mask;
  logic [31:0]            read_word;

  // external pins cross into pclk before use
  pin_sync u_sync_ext0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (ext_irq0_input_n),
    .level_out (ext0_level)
  );
  pin_sync u_sync_ext1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (ext_irq1_input_n),
    .level_out (ext1_level)
  );

  // either timer 2 overflow half raises the one timer 2 request
  assign timer2_any = flags.timer2_low_overflow_flag | flags.timer2_high_overflow_flag;

  // pending sources, in mask bit order
  always_comb begin
    pend = '0;
    pend[spi_bit]    = flags.spi_flag;
    pend[timer2_bit] = timer2_any;
    pend[uart_bit]   = flags.uart_flag;
    pend[timer1_bit] = flags.timer1_overflow_flag;
    pend[ext1_bit]   = ~ext1_level;
    pend[timer0_bit] = flags.timer0_overflow_flag;
    pend[ext0_bit]   = ~ext0_level;
  end

  // individual enables gathered in source order
  always_comb begin
    src_enable = '0;
    src_enable[spi_bit]    = mask_reg.serial_periph_irq_enable;
    src_enable[timer2_bit] = mask_reg.timer2_irq_enable;
    src_enable[uart_bit]   = mask_reg.uart_irq_enable;
    src_enable[timer1_bit] = mask_reg.timer1_irq_enable;
    src_enable[ext1_bit]   = mask_reg.ext_irq1_enable;
    src_enable[timer0_bit] = mask_reg.timer0_irq_enable;
    src_enable[ext0_bit]   = mask_reg.ext_irq0_enable;
  end

  // gating; a cleared global enable overrides every individual mask
  always_comb begin
    irq_next = '0;
    if (mask_reg.global_irq_enable) begin
      irq_next = pend & src_enable;
    end
  end

  // one flop of latency keeps the requests to the core glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  // address decode; any other word answers with an error
  assign sel_mask    = (paddr == mask_reg_offset);
  assign sel_status  = (paddr == status_reg_offset);
  assign sel_pending = (paddr == pending_reg_offset);
  assign mapped      = sel_mask | sel_status | sel_pending;

  // the first access-phase edge is taken; pready high blocks a second take
  assign access  = psel & penable & ~pready_reg;
  // only the low lane carries the mask; status and pending are read only
  assign wr_mask = access & pwrite & sel_mask & pstrb[mask_lane];

  // response: one wait state, then a one-cycle pready pulse
  always_comb begin
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (access) begin
      pready_next  = 1'b1;
      pslverr_next = ~mapped;
    end
  end

  // response flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // mask write lands in the wait state, one edge before the master sees pready
  always_comb begin
    mask_next = mask_reg;
    if (wr_mask) begin
      mask_next.global_irq_enable        = pwdata[global_bit];
      mask_next.serial_periph_irq_enable = pwdata[spi_bit];
      mask_next.timer2_irq_enable        = pwdata[timer2_bit];
      mask_next.uart_irq_enable          = pwdata[uart_bit];
      mask_next.timer1_irq_enable        = pwdata[timer1_bit];
      mask_next.ext_irq1_enable          = pwdata[ext1_bit];
      mask_next.timer0_irq_enable        = pwdata[timer0_bit];
      mask_next.ext_irq0_enable          = pwdata[ext0_bit];
    end
  end

  // mask flops; cleared on reset so nothing reaches the core until software opts in
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= irq_mask_t'(mask_reset_value);
    end else begin
      mask_reg <= mask_next;
    end
  end

  // read mux; upper bits read as zero
  always_comb begin
    case (paddr)
      mask_reg_offset:    read_word = {{mask_pad{1'b0}}, mask_reg};
      status_reg_offset:  read_word = {{src_pad{1'b0}}, irq_reg};
      pending_reg_offset: read_word = {{src_pad{1'b0}}, pend};
      default:            read_word = unmapped_read_value;
    endcase
  end

  // read data loads with pready and then holds, so a late sample still sees it
  always_comb begin
    prdata_next = prdata_reg;
    if (access) begin
      prdata_next = unmapped_read_value;
      if (!pwrite) begin
        prdata_next = read_word;
      end
    end
  end

  // read data flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  // bus outputs straight from flops
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;

  // request outputs straight from flops
  assign irq_to_core = irq_reg;
endmodule // interrupt_enable_mask
`default_nettype wire

/* File: dv/interrupt_enable_mask_monitor.sv */
// checker: apb timing and request gating
`default_nettype none
module interrupt_enable_mask_monitor
  import irq_mask_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire irq_flags_t             flags,
  input wire logic [num_sources-1:0] irq_to_core
);
  logic [7:0] m_reg;
  logic [7:0] m_next;
  logic       t2_any;
  // either timer 2 half counts as the one timer 2 source
  assign t2_any = flags.timer2_low_overflow_flag | flags.timer2_high_overflow_flag;
  // shadow mask, taken at write completion so it lines up with the outputs
  always_comb begin
    m_next = m_reg;
    if (psel && penable && pready && pwrite && paddr == mask_reg_offset && pstrb[0])
      m_next = pwdata[7:0];
  end
  // shadow register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      m_reg <= mask_reset_value;
    else
      m_reg <= m_next;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property gate_p(int i, logic f);
    irq_to_core[i] == ($past(f) && m_reg[i] && m_reg[7]);
  endproperty
  AST_WAIT: assert property (psel && penable && !pready |=> pready ##1 !pready) else $error("pready timing");
  AST_ERR: assert property (psel && penable && !pready && paddr > pending_reg_offset |=> pslverr) else $error("no slverr");
  AST_T0: assert property (gate_p(timer0_bit, flags.timer0_overflow_flag)) else $error("timer0 gate");
  AST_T1: assert property (gate_p(timer1_bit, flags.timer1_overflow_flag)) else $error("timer1 gate");
  AST_T2: assert property (gate_p(timer2_bit, t2_any)) else $error("timer2 gate");
  AST_UART: assert property (gate_p(uart_bit, flags.uart_flag)) else $error("uart gate");
  AST_SPI: assert property (gate_p(spi_bit, flags.spi_flag)) else $error("spi gate");
  AST_EXT0: assert property (!m_reg[ext0_bit] |-> !irq_to_core[ext0_bit]) else $error("ext0 gate");
  AST_EXT1: assert property (!m_reg[ext1_bit] |-> !irq_to_core[ext1_bit]) else $error("ext1 gate");
  AST_GLOBAL: assert property (!m_reg[7] |-> irq_to_core == '0) else $error("global gate");
  C_WR: cover property (psel && penable && pready && pwrite);
  C_ERR: cover property (pslverr);
  C_IRQ: cover property (irq_to_core != '0);
  C_T2_HIGH: cover property (irq_to_core[timer2_bit] && flags.timer2_high_overflow_flag);
endmodule  // interrupt_enable_mask_monitor
bind interrupt_enable_mask interrupt_enable_mask_monitor interrupt_enable_mask_monitor_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .flags(flags), .irq_to_core(irq_to_core));
`default_nettype wire

/* File: dv/irq_source_model.sv */
// partner: peripheral flags and external pins
`default_nettype none
module irq_source_model
  import irq_mask_pkg::*;
(
  input wire logic [6:0] act,
  input wire logic t2_hi,
  output var irq_flags_t flags,
  output var logic ext_irq0_input_n,
  output var logic ext_irq1_input_n
);
  // active sources hold their level; pins are active low
  always_comb begin
    flags = '{act[6], act[5] && !t2_hi, act[5] && t2_hi, act[4], act[3], act[1]};
    ext_irq0_input_n = !act[0];
    ext_irq1_input_n = !act[2];
  end
endmodule  // irq_source_model
`default_nettype wire

/* File: dv/interrupt_enable_mask_tb_top.sv */
// testbench: register access and request gating
`default_nettype none
module interrupt_enable_mask_tb_top import irq_mask_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, t2_hi, e0, e1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [6:0] act, irq;
  irq_flags_t flags;
  int error_cnt, cmp_count;
  interrupt_enable_mask interrupt_enable_mask_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flags(flags), .ext_irq0_input_n(e0), .ext_irq1_input_n(e1), .irq_to_core(irq));
  irq_source_model irq_source_model_i (.act(act), .t2_hi(t2_hi), .flags(flags), .ext_irq0_input_n(e0),
    .ext_irq1_input_n(e1));
  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // one apb transfer, held until pready; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic t_regs;
    apb(0, mask_reg_offset, 0);
    chk(rd, {24'h0, mask_reset_value});
    chk({31'h0, er}, 32'h0);
    apb(1, mask_reg_offset, 32'h1a5);
    pstrb <= 4'he;
    apb(1, mask_reg_offset, 32'hff);
    pstrb <= 4'hf;
    apb(1, status_reg_offset, 32'hff);
    apb(0, mask_reg_offset, 0);
    chk(rd, 32'ha5);
    apb(0, 12'h00c, 0);
    chk({31'h0, er}, 32'h1);
    chk(rd, unmapped_read_value);
  endtask
  // one mask bit at a time, global off then on, timer2 low then high flag
  task automatic t_gate;
    logic [7:0] m;
    logic [6:0] x;
    act <= 7'h7f;
    for (int k = 0; k < 24; k++) begin
      m = (8'h01 << (k % 8)) | (k > 7 ? 8'h80 : 8'h00);
      x = m[6:0] & {7{m[7]}};
      t2_hi <= k > 15;
      apb(1, mask_reg_offset, {24'h0, m});
      repeat (8) @(posedge pclk);
      chk({25'h0, irq}, {25'h0, x});
      apb(0, status_reg_offset, 0);
      chk(rd, {25'h0, x});
    end
    apb(0, pending_reg_offset, 0);
    chk(rd, 32'h7f);
    act <= 7'h00;
    apb(1, mask_reg_offset, 32'hff);
    repeat (8) @(posedge pclk);
    chk({25'h0, irq}, 32'h0);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog well past the expected few hundred cycles
  initial begin
    #20us;
    error_cnt++;
    give_verdict;
  end
  initial begin
    {presetn, psel, penable, pwrite, t2_hi, paddr, pwdata, act} = '0;
    pstrb = 4'hf;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_gate;
    give_verdict;
  end
endmodule  // interrupt_enable_mask_tb_top
`default_nettype wire
